// File: hdl/radio_pkt_dev.sv
// Radio packet handler: TX modulator byte fetch, RX FIFO, flags and overflow
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
// How it works
// - Variable packet: length, payload, two status
// - Host sets limit 62 in fixed mode
// - Host drains FIFO before 64 bytes
// - Fetch strobe high first half of byte
// - Packet mode leaves TX after last bit
// - Host idles after 12 dummy bits
// - Flags set only on input condition
// - End input sets, clears on first read
// - Append CRC-OK status after packet
// - Over 65 unread bytes means overflow
// - Host recovers by idle then flush
// - Overflow deasserts pin at config 0x06
module radio_pkt_dev (
   input wire logic clk_sys,
   input wire logic rst_n,
   radio_pkt_if.dev bus,
   input wire logic rf_bit_valid,
   input wire logic rf_bit,
   input wire logic rf_crc_ok,
   input wire logic rf_pkt_end,
   output logic tx_bit_valid,
   output logic tx_bit,
   output logic mod_fetch
);
   radio_pkt_pkg::radio_state_t state_r;
   logic [7:0] rx_mem_r [0:radio_pkt_pkg::RX_DEPTH-1];
   logic [5:0] wr_ptr_r, rd_ptr_r;
   logic [6:0] cnt_r;
   logic [7:0] prefetch_r;
   logic prefetch_full_r;
   logic [7:0] tx_hold_r, tx_shift_r;
   logic tx_hold_full_r;
   logic [2:0] tx_bitpos_r;
   logic tx_active_r;
   logic [7:0] tx_left_r;
   logic [5:0] bit_div_r;
   logic bit_en;
   logic [7:0] rx_shift_r;
   logic [2:0] rx_bitpos_r;
   logic [1:0] stat_left_r;
   logic rx_end_r, pkt_end_seen_r;
   logic [7:0] irq_in_r, irq_in_d_r, flag_r;
   logic byte_in;
   logic [7:0] byte_val;
   logic fifo_wr, fifo_rd, go_ovf;
   logic crc_ok_r;

   assign fifo_rd = bus.rx_pop && cnt_r != 7'h00;
   // Bit timing enable for the modulator and fetch strobe; the receiver runs on rf_bit_valid
   assign bit_en = bit_div_r == 6'(radio_pkt_pkg::BIT_CYCLES - 1);
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bit_div_r <= 6'h00;
      end else if (bit_en) begin
         bit_div_r <= 6'h00;
      end else begin
         bit_div_r <= bit_div_r + 6'h01;
      end
   end

   // Radio state; idle strobe ends TX, RX and overflow
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= radio_pkt_pkg::RS_IDLE;
      end else if (bus.idle_strobe) begin
         state_r <= radio_pkt_pkg::RS_IDLE;
      end else begin
         unique case (state_r)
            radio_pkt_pkg::RS_IDLE: begin
               if (bus.tx_start) begin
                  state_r <= radio_pkt_pkg::RS_TX;
               end else if (bus.rx_start) begin
                  state_r <= radio_pkt_pkg::RS_RX;
               end
            end
            radio_pkt_pkg::RS_TX: begin
               if (bus.modem_config_two && bit_en && tx_active_r && tx_left_r == 8'h00
                   && tx_bitpos_r == 3'h7) begin
                  state_r <= radio_pkt_pkg::RS_IDLE;
               end
            end
            radio_pkt_pkg::RS_RX: begin
               if (go_ovf) begin
                  state_r <= radio_pkt_pkg::RS_RX_OVF;
               end
            end
            radio_pkt_pkg::RS_RX_OVF: begin
            end
         endcase
      end
   end

   // TX holding byte from host; refused while full
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_hold_r <= 8'h00;
         tx_hold_full_r <= 1'b0;
      end else if (bus.tx_push && !tx_hold_full_r) begin
         tx_hold_r <= bus.tx_data;
         tx_hold_full_r <= 1'b1;
      end else if (state_r == radio_pkt_pkg::RS_TX && bit_en && tx_bitpos_r == 3'h0) begin
         tx_hold_full_r <= 1'b0;
      end
   end

   // Modulator shifter; packet mode sends length byte or fixed limit count, else dummies after data
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_shift_r <= 8'h00;
         tx_bitpos_r <= 3'h0;
         tx_active_r <= 1'b0;
         tx_left_r <= 8'h00;
         tx_bit_valid <= 1'b0;
         tx_bit <= 1'b0;
      end else if (state_r != radio_pkt_pkg::RS_TX) begin
         tx_bitpos_r <= 3'h0;
         tx_active_r <= 1'b0;
         tx_left_r <= bus.packet_length_limit;
         tx_bit_valid <= 1'b0;
      end else if (bit_en) begin
         tx_bit_valid <= 1'b1;
         if (tx_bitpos_r == 3'h0) begin
            tx_shift_r <= tx_hold_full_r ? tx_hold_r : 8'h00;
            tx_bit <= tx_hold_full_r ? tx_hold_r[7] : 1'b0;
            tx_active_r <= 1'b1;
            // First byte sets the count: length byte, or fixed limit less one
            if (!tx_active_r) begin
               tx_left_r <= bus.packet_control_zero ? tx_hold_r
                  : bus.packet_length_limit - 8'h01;
            end else if (tx_left_r != 8'h00) begin
               tx_left_r <= tx_left_r - 8'h01;
            end
         end else begin
            tx_bit <= tx_shift_r[3'h7 - tx_bitpos_r];
         end
         tx_bitpos_r <= tx_bitpos_r + 3'h1;
      end else begin
         tx_bit_valid <= 1'b0;
      end
   end

   // Byte fetch strobe: raised at byte start, dropped at half byte
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mod_fetch <= 1'b0;
      end else if (state_r != radio_pkt_pkg::RS_TX) begin
         mod_fetch <= 1'b0;
      end else if (bit_en) begin
         // assert at start, drop at half
         if (tx_bitpos_r == 3'h0) begin
            mod_fetch <= 1'b1;
         end else if (tx_bitpos_r == radio_pkt_pkg::BYTE_HALF) begin
            mod_fetch <= 1'b0;
         end
      end
   end

   // Receive deserialiser and packet framing with appended status
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_shift_r <= 8'h00;
         rx_bitpos_r <= 3'h0;
         stat_left_r <= 2'h0;
         pkt_end_seen_r <= 1'b0;
         crc_ok_r <= 1'b0;
      end else if (state_r != radio_pkt_pkg::RS_RX) begin
         rx_bitpos_r <= 3'h0;
         stat_left_r <= 2'h0;
         pkt_end_seen_r <= 1'b0;
      end else begin
         if (stat_left_r != 2'h0) begin
            stat_left_r <= stat_left_r - 2'h1;
            pkt_end_seen_r <= stat_left_r == 2'h1;
         end else if (rf_bit_valid) begin
            rx_shift_r <= {rx_shift_r[6:0], rf_bit};
            rx_bitpos_r <= rx_bitpos_r + 3'h1;
         end
         if (rf_pkt_end) begin
            crc_ok_r <= rf_crc_ok;
            // two status bytes if packet_control_one, else none; CRC-OK in MSB
            stat_left_r <= bus.packet_control_one ? 2'h2 : 2'h1;
         end else if (stat_left_r == 2'h0 && (!prefetch_full_r || fifo_wr)) begin
            // Held until the final byte leaves the prefetch for the FIFO
            pkt_end_seen_r <= 1'b0;
         end
      end
   end

   // length, payload, then the status bytes
   always_comb begin
      byte_in = 1'b0;
      byte_val = 8'h00;
      if (state_r == radio_pkt_pkg::RS_RX) begin
         if (stat_left_r == 2'h2) begin
            byte_in = 1'b1;
            byte_val = radio_pkt_pkg::RSSI_STAT;
         end else if (stat_left_r == 2'h1) begin
            byte_in = bus.packet_control_one;
            byte_val = (crc_ok_r ? radio_pkt_pkg::CRC_OK_STAT : 8'h00) | radio_pkt_pkg::LQI_STAT;
         end else if (rf_bit_valid && rx_bitpos_r == 3'h7) begin
            byte_in = 1'b1;
            byte_val = {rx_shift_r[6:0], rf_bit};
         end
      end
   end

   // FIFO and prefetch both full on a new byte
   assign go_ovf = byte_in && prefetch_full_r && cnt_r == radio_pkt_pkg::RX_DEPTH_C && !fifo_rd;
   assign fifo_wr = prefetch_full_r && (cnt_r != radio_pkt_pkg::RX_DEPTH_C || fifo_rd);

   // Prefetch byte, then FIFO storage
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prefetch_r <= 8'h00;
         prefetch_full_r <= 1'b0;
      end else if (bus.rx_flush_strobe && state_r != radio_pkt_pkg::RS_RX) begin
         prefetch_full_r <= 1'b0;
      end else if (byte_in && (!prefetch_full_r || fifo_wr)) begin
         prefetch_r <= byte_val;
         prefetch_full_r <= 1'b1;
      end else if (fifo_wr) begin
         prefetch_full_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (fifo_wr) begin
         rx_mem_r[wr_ptr_r] <= prefetch_r;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_r <= 6'h00;
         rd_ptr_r <= 6'h00;
         cnt_r <= 7'h00;
      end else if (bus.rx_flush_strobe && state_r != radio_pkt_pkg::RS_RX) begin
         wr_ptr_r <= 6'h00;
         rd_ptr_r <= 6'h00;
         cnt_r <= 7'h00;
      end else begin
         wr_ptr_r <= wr_ptr_r + 6'(fifo_wr);
         rd_ptr_r <= rd_ptr_r + 6'(fifo_rd);
         cnt_r <= cnt_r + 7'(fifo_wr) - 7'(fifo_rd);
      end
   end

   // Read data registered one cycle after the pop
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bus.rx_data <= 8'h00;
         bus.rx_valid <= 1'b0;
      end else begin
         bus.rx_data <= fifo_rd ? rx_mem_r[rd_ptr_r] : 8'h00;
         bus.rx_valid <= fifo_rd;
      end
   end

   // end input sets on last byte, clears on first read
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_end_r <= 1'b0;
      end else if (pkt_end_seen_r && stat_left_r == 2'h0 && (!prefetch_full_r || fifo_wr)) begin
         rx_end_r <= 1'b1;
      end else if (fifo_rd || bus.rx_flush_strobe) begin
         rx_end_r <= 1'b0;
      end
   end

   // flags follow FIFO-mapped inputs; bits 9 and 10 on falling edge
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_in_r <= 8'h00;
         irq_in_d_r <= 8'h00;
         flag_r <= 8'h00;
      end else begin
         irq_in_r <= {rx_end_r, state_r != radio_pkt_pkg::RS_RX_OVF && prefetch_full_r,
            state_r == radio_pkt_pkg::RS_RX_OVF, cnt_r == 7'h00, cnt_r >= 7'h20,
            tx_hold_full_r, state_r == radio_pkt_pkg::RS_TX, state_r == radio_pkt_pkg::RS_RX};
         irq_in_d_r <= irq_in_r;
         // Set wins over a simultaneous clear
         flag_r <= (flag_r & ~(bus.irq_clear ? bus.irq_clear_bits : 8'h00))
            | (radio_pkt_pkg::FALL_EDGE_SEL & irq_in_d_r & ~irq_in_r)
            | (~radio_pkt_pkg::FALL_EDGE_SEL & irq_in_r & ~irq_in_d_r);
      end
   end

   // pin follows overflow inverted at config 0x06
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bus.gdo_out <= 1'b0;
         bus.radio_irq <= 1'b0;
         bus.rx_count <= 7'h00;
         bus.tx_ready <= 1'b0;
         bus.radio_state <= 4'h1;
      end else begin
         bus.gdo_out <= bus.gdo_pin_config == radio_pkt_pkg::GDO_CFG_RX_OVF ?
            state_r != radio_pkt_pkg::RS_RX_OVF : 1'b0;
         bus.radio_irq <= |(flag_r & bus.radio_irq_mask);
         bus.rx_count <= cnt_r;
         bus.tx_ready <= !tx_hold_full_r && !bus.tx_push;
         bus.radio_state <= state_r;
      end
   end

   assign bus.radio_irq_flag = flag_r;
   assign bus.radio_irq_input = irq_in_r;
   assign bus.rx_end_input = rx_end_r;
   assign bus.rx_alt_input = irq_in_r[6];
endmodule

// File: include/radio_pkt_pkg.sv
// Shared constants and types for the radio packet FIFO controller and its host
package radio_pkt_pkg;
   localparam int RX_DEPTH = 64;
   localparam logic [6:0] RX_DEPTH_C = 7'h40;
   localparam logic [6:0] RX_LIMIT_OVF = 7'h41;
   localparam logic [7:0] PKT_LEN_VAR_MAX = 8'h3d;
   localparam logic [7:0] PKT_LEN_FIX_MAX = 8'h3e;
   localparam logic LEN_FIXED = 1'b0;
   localparam logic LEN_VARIABLE = 1'b1;
   localparam logic [5:0] GDO_CFG_RX_OVF = 6'h06;
   localparam logic [2:0] BYTE_HALF = 3'h4;
   localparam logic [3:0] IDLE_DUMMY_BITS = 4'hc;
   localparam logic [3:0] TX_LATENCY_BITS = 4'h8;
   localparam int BIT_TIME_NS = 2000;
   localparam int CLK_PERIOD_NS = 50;
   localparam int BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;
   localparam int FLAG_LO = 3;
   localparam int FLAG_HI = 10;
   localparam int FLAG_W = 8;
   localparam logic [7:0] IRQ_MASK_RST = 8'h00;
   localparam logic [7:0] FALL_EDGE_SEL = 8'hc0;
   localparam logic [7:0] CRC_OK_STAT = 8'h80;
   localparam logic [7:0] LQI_STAT = 8'h00;
   localparam logic [7:0] RSSI_STAT = 8'h00;
   localparam logic [3:0] HREG_CTRL = 4'h0;
   localparam logic [3:0] HREG_TXDATA = 4'h1;
   localparam logic [3:0] HREG_RXDATA = 4'h2;
   localparam logic [3:0] HREG_STATUS = 4'h3;
   localparam logic [3:0] HREG_IRQ_STAT = 4'h4;
   localparam logic [3:0] HREG_IRQ_MASK = 4'h5;
   localparam logic [3:0] HREG_CFG = 4'h6;
   localparam logic [3:0] HREG_CMD = 4'h7;
   localparam int CMD_TX = 0;
   localparam int CMD_IDLE = 1;
   localparam int CMD_RX_FLUSH = 2;
   localparam int CMD_RX = 3;
   typedef enum logic [3:0] {
      RS_IDLE = 4'b0001,
      RS_TX = 4'b0010,
      RS_RX = 4'b0100,
      RS_RX_OVF = 4'b1000
   } radio_state_t;
endpackage

// File: include/radio_pkt_if.sv
// Link between the radio packet FIFO controller and the host processor end
`timescale 1ns/1ps
interface radio_pkt_if;
   logic [7:0] packet_length_limit;
   logic packet_control_zero;
   logic packet_control_one;
   logic modem_config_two;
   logic [5:0] gdo_pin_config;
   logic [7:0] radio_irq_mask;
   logic [7:0] tx_data;
   logic tx_push;
   logic tx_start;
   logic rx_start;
   logic idle_strobe;
   logic rx_flush_strobe;
   logic rx_pop;
   logic irq_clear;
   logic [7:0] irq_clear_bits;
   logic [7:0] rx_data;
   logic rx_valid;
   logic [6:0] rx_count;
   logic [3:0] radio_state;
   logic [7:0] radio_irq_flag;
   logic [7:0] radio_irq_input;
   logic rx_end_input;
   logic rx_alt_input;
   logic gdo_out;
   logic tx_ready;
   logic radio_irq;
   modport dev (
      input packet_length_limit, packet_control_zero, packet_control_one, modem_config_two,
      input gdo_pin_config, radio_irq_mask, tx_data, tx_push, tx_start, rx_start,
      input idle_strobe, rx_flush_strobe, rx_pop, irq_clear, irq_clear_bits,
      output rx_data, rx_valid, rx_count, radio_state, radio_irq_flag, radio_irq_input,
      output rx_end_input, rx_alt_input, gdo_out, tx_ready, radio_irq
   );
   modport host (
      output packet_length_limit, packet_control_zero, packet_control_one, modem_config_two,
      output gdo_pin_config, radio_irq_mask, tx_data, tx_push, tx_start, rx_start,
      output idle_strobe, rx_flush_strobe, rx_pop, irq_clear, irq_clear_bits,
      input rx_data, rx_valid, rx_count, radio_state, radio_irq_flag, radio_irq_input,
      input rx_end_input, rx_alt_input, gdo_out, tx_ready, radio_irq
   );
endinterface

// File: hdl/radio_pkt_host.sv
// Host end: register port for software, drives radio strobes and FIFO traffic
`timescale 1ns/1ps
module radio_pkt_host (
   input wire logic clk_sys,
   input wire logic rst_n,
   radio_pkt_if.host bus,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   output logic irq
);
   logic [7:0] cfg_len_r, mask_r, ctrl_r;
   logic [7:0] rdata_r;
   logic pop_d_r;
   logic [5:0] gdo_r;
   logic [3:0] dummy_cnt_r;
   logic idle_pend_r;
   logic [5:0] bit_div_r;

   assign bus.packet_length_limit = cfg_len_r;
   assign bus.packet_control_zero = ctrl_r[0];
   assign bus.packet_control_one = ctrl_r[1];
   assign bus.modem_config_two = ctrl_r[2];
   assign bus.gdo_pin_config = gdo_r;
   assign bus.radio_irq_mask = mask_r;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg_len_r <= radio_pkt_pkg::PKT_LEN_VAR_MAX;
         ctrl_r <= 8'h07;
         gdo_r <= radio_pkt_pkg::GDO_CFG_RX_OVF;
         mask_r <= radio_pkt_pkg::IRQ_MASK_RST;
      end else if (wr) begin
         unique case (addr)
            radio_pkt_pkg::HREG_CTRL: ctrl_r <= wdata;
            radio_pkt_pkg::HREG_IRQ_MASK: mask_r <= wdata;
            radio_pkt_pkg::HREG_CFG: begin
               // set limit to the length mode's maximum so the packet fits the FIFO
               if (wdata[0] == radio_pkt_pkg::LEN_VARIABLE) begin
                  cfg_len_r <= radio_pkt_pkg::PKT_LEN_VAR_MAX;
               end else begin
                  cfg_len_r <= radio_pkt_pkg::PKT_LEN_FIX_MAX;
               end
               gdo_r <= wdata[7:2];
            end
            default: begin
            end
         endcase
      end
   end

   // Strobes: one cycle each
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bus.tx_push <= 1'b0;
         bus.tx_data <= 8'h00;
         bus.tx_start <= 1'b0;
         bus.rx_start <= 1'b0;
         bus.rx_flush_strobe <= 1'b0;
         bus.irq_clear <= 1'b0;
         bus.irq_clear_bits <= 8'h00;
      end else begin
         bus.tx_push <= wr && addr == radio_pkt_pkg::HREG_TXDATA;
         bus.tx_data <= wdata;
         bus.tx_start <= wr && addr == radio_pkt_pkg::HREG_CMD && wdata[radio_pkt_pkg::CMD_TX];
         bus.rx_start <= wr && addr == radio_pkt_pkg::HREG_CMD && wdata[radio_pkt_pkg::CMD_RX];
         // flush only after idle has taken effect
         bus.rx_flush_strobe <= wr && addr == radio_pkt_pkg::HREG_CMD
            && wdata[radio_pkt_pkg::CMD_RX_FLUSH] && bus.radio_state == 4'h1;
         bus.irq_clear <= wr && addr == radio_pkt_pkg::HREG_IRQ_STAT;
         bus.irq_clear_bits <= wdata;
      end
   end

   // manual idle held back for 12 dummy bit times when packet mode is off and the radio is in TX
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bit_div_r <= 6'h00;
         dummy_cnt_r <= 4'h0;
         idle_pend_r <= 1'b0;
         bus.idle_strobe <= 1'b0;
      end else begin
         bit_div_r <= bit_div_r == 6'(radio_pkt_pkg::BIT_CYCLES - 1) ? 6'h00 : bit_div_r + 6'h01;
         bus.idle_strobe <= 1'b0;
         if (wr && addr == radio_pkt_pkg::HREG_CMD && wdata[radio_pkt_pkg::CMD_IDLE]) begin
            if (!ctrl_r[2] && bus.radio_state == 4'h2) begin
               idle_pend_r <= 1'b1;
               dummy_cnt_r <= radio_pkt_pkg::IDLE_DUMMY_BITS;
            end else begin
               bus.idle_strobe <= 1'b1;
            end
         end else if (idle_pend_r && bit_div_r == 6'h00) begin
            if (dummy_cnt_r == 4'h0) begin
               idle_pend_r <= 1'b0;
               bus.idle_strobe <= 1'b1;
            end else begin
               dummy_cnt_r <= dummy_cnt_r - 4'h1;
            end
         end
      end
   end

   // pop request, read data one cycle later
   assign bus.rx_pop = rd && addr == radio_pkt_pkg::HREG_RXDATA;
   // FIFO byte is already registered in the controller, so it bypasses rdata_r
   assign rdata = pop_d_r ? bus.rx_data : rdata_r;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 8'h00;
         pop_d_r <= 1'b0;
         irq <= 1'b0;
      end else begin
         irq <= bus.radio_irq;
         pop_d_r <= bus.rx_pop;
         rdata_r <= 8'h00;
         if (rd) begin
            unique case (addr)
               radio_pkt_pkg::HREG_CTRL: rdata_r <= ctrl_r;
               radio_pkt_pkg::HREG_STATUS: rdata_r <= {bus.radio_state, bus.gdo_out,
                  bus.rx_end_input, bus.tx_ready, idle_pend_r};
               radio_pkt_pkg::HREG_IRQ_STAT: rdata_r <= bus.radio_irq_flag;
               radio_pkt_pkg::HREG_IRQ_MASK: rdata_r <= mask_r;
               radio_pkt_pkg::HREG_CFG: rdata_r <= {gdo_r, 1'b0,
                  cfg_len_r == radio_pkt_pkg::PKT_LEN_VAR_MAX};
               radio_pkt_pkg::HREG_CMD: rdata_r <= {1'b0, bus.rx_count};
               default: rdata_r <= 8'h00;
            endcase
         end
      end
   end
endmodule

// File: dv/radio_pkt_assertions.sv
// Concurrent checks on the link between the packet controller and its host
`timescale 1ns/1ps
module radio_pkt_assertions (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [6:0] rx_count,
   input wire logic [3:0] radio_state,
   input wire logic rx_pop,
   input wire logic rx_valid,
   input wire logic [7:0] radio_irq_flag,
   input wire logic [7:0] radio_irq_input,
   input wire logic [7:0] radio_irq_mask,
   input wire logic radio_irq,
   input wire logic rx_end_input,
   input wire logic [5:0] gdo_pin_config,
   input wire logic gdo_out,
   input wire logic idle_strobe
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_fifo_bound: assert property (rx_count <= radio_pkt_pkg::RX_DEPTH_C)
      else $error("fifo count above limit");
   a_ovf_when_full: assert property ($rose(radio_state == radio_pkt_pkg::RS_RX_OVF)
      |-> rx_count == radio_pkt_pkg::RX_DEPTH_C) else $error("overflow at wrong count");
   a_gdo_ovf_low: assert property ((radio_state == radio_pkt_pkg::RS_RX_OVF
      && gdo_pin_config == radio_pkt_pkg::GDO_CFG_RX_OVF) [*2] |-> !gdo_out)
      else $error("pin high in overflow");
   a_pop_gives_data: assert property (rx_pop && rx_count != 7'h0 |=> rx_valid)
      else $error("no data after pop");
   a_flag_has_cause: assert property ($rose(radio_irq_flag[0])
      |-> $past(radio_irq_input[0]) || $past(radio_irq_input[0], 2))
      else $error("flag set without cause");
   a_end_flag_fall: assert property ($rose(radio_irq_flag[7])
      |-> $past(rx_end_input, 2) || $past(rx_end_input, 3)) else $error("end flag no fall");
   a_irq_follows: assert property ($stable(radio_irq_flag & radio_irq_mask)
      |-> radio_irq == |(radio_irq_flag & radio_irq_mask)) else $error("irq level wrong");
   a_end_clears: assert property (rx_pop && rx_end_input |-> ##[1:2] !rx_end_input)
      else $error("end input stays set");
   a_idle_exits: assert property (idle_strobe |-> ##[1:2]
      radio_state == radio_pkt_pkg::RS_IDLE) else $error("idle strobe ignored");
   c_overflow: cover property (radio_state == radio_pkt_pkg::RS_RX_OVF);
   c_end_fall: cover property ($fell(rx_end_input));
   c_irq: cover property (radio_irq);
endmodule

// File: dv/radio_packet_fifo_ctrl_tb_top.sv
// Self-checking bench: host end and controller joined over the packet link
`timescale 1ns/1ps
module radio_packet_fifo_ctrl_tb_top;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_d = 1'b0;
   logic rf_bit_valid = 1'b0;
   logic rf_bit = 1'b0;
   logic rf_crc_ok = 1'b0;
   logic rf_pkt_end = 1'b0;
   logic [7:0] rdata;
   logic irq, tx_bit_valid, tx_bit, mod_fetch;
   logic [31:0] lfsr = 32'h426f;
   logic [7:0] tsh = 8'h00;
   logic [7:0] n = 8'h00;
   logic [7:0] b = 8'h00;
   logic [7:0] rq[$];
   logic [7:0] tq[$];
   logic [7:0] pl[$];
   int tn = 0;
   int err_count = 0;
   int n_compared = 0;
   radio_pkt_if bus ();
   radio_pkt_dev radio_pkt_dev_i (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
      .rf_bit_valid(rf_bit_valid), .rf_bit(rf_bit), .rf_crc_ok(rf_crc_ok),
      .rf_pkt_end(rf_pkt_end), .tx_bit_valid(tx_bit_valid), .tx_bit(tx_bit),
      .mod_fetch(mod_fetch));
   radio_pkt_host radio_pkt_host_i (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
   radio_pkt_assertions radio_pkt_assertions_i (.clk_sys(clk_sys), .rst_n(rst_n),
      .rx_count(bus.rx_count), .radio_state(bus.radio_state), .rx_pop(bus.rx_pop),
      .rx_valid(bus.rx_valid), .radio_irq_flag(bus.radio_irq_flag),
      .radio_irq_input(bus.radio_irq_input), .radio_irq_mask(bus.radio_irq_mask),
      .radio_irq(bus.radio_irq), .rx_end_input(bus.rx_end_input),
      .gdo_pin_config(bus.gdo_pin_config), .gdo_out(bus.gdo_out),
      .idle_strobe(bus.idle_strobe));
   initial forever #25 clk_sys = ~clk_sys;
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr[7:0];
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys);
   endtask
   // One strobe cycle; the following edge drops it so calls never collide
   task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk_sys);
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a, input logic [7:0] e);
      rq.push_back(e);
      acc(1'b0, a, 8'h00);
   endtask
   task automatic cmd(input logic [7:0] d);
      acc(1'b1, radio_pkt_pkg::HREG_CMD, d);
   endtask
   task automatic send_tx(input logic [7:0] d);
      tq.push_back(d);
      acc(1'b1, radio_pkt_pkg::HREG_TXDATA, d);
   endtask
   task automatic rx_byte(input logic [7:0] d);
      for (int i = 7; i >= 0; i--) begin
         @(posedge clk_sys);
         rf_bit <= d[i];
         rf_bit_valid <= 1'b1;
         @(posedge clk_sys);
         rf_bit_valid <= 1'b0;
      end
   endtask
   always @(posedge clk_sys) rd_d <= rd;
   // Sampled mid-cycle so register updates at the edge have settled
   always @(negedge clk_sys) begin
      if (rd_d && rq.size() > 0) chk(rdata, rq.pop_front());
      if (tx_bit_valid === 1'b1) begin
         tsh = {tsh[6:0], tx_bit};
         chk({7'h0, mod_fetch}, {7'h0, tn < 4});
         tn++;
         if (tn == 8 && tq.size() > 0) chk(tsh, tq.pop_front());
         if (tn == 8) tn = 0;
      end else if (bus.radio_state === radio_pkt_pkg::RS_IDLE) tn = 0;
   end
   initial begin
      cyc(6);
      rst_n <= 1'b1;
      rreg(radio_pkt_pkg::HREG_CTRL, 8'h07);
      acc(1'b1, radio_pkt_pkg::HREG_IRQ_MASK, 8'h80);
      acc(1'b1, radio_pkt_pkg::HREG_CFG, 8'h18);
      rreg(radio_pkt_pkg::HREG_CFG, 8'h18);
      acc(1'b1, radio_pkt_pkg::HREG_CFG, 8'h19);
      rreg(radio_pkt_pkg::HREG_CFG, 8'h19);
      for (int k = 0; k < 4; k++) begin
         pl.delete();
         rf_crc_ok <= k[0];
         cmd(8'h08);
         n = (k < 2) ? 8'h03 : radio_pkt_pkg::PKT_LEN_VAR_MAX;
         rx_byte(n);
         repeat (n) begin
            b = rnd();
            pl.push_back(b);
            rx_byte(b);
         end
         @(posedge clk_sys);
         rf_pkt_end <= 1'b1;
         @(posedge clk_sys);
         rf_pkt_end <= 1'b0;
         cyc(4);
         rreg(radio_pkt_pkg::HREG_RXDATA, n);
         foreach (pl[i]) rreg(radio_pkt_pkg::HREG_RXDATA, pl[i]);
         rreg(radio_pkt_pkg::HREG_RXDATA, radio_pkt_pkg::RSSI_STAT);
         rreg(radio_pkt_pkg::HREG_RXDATA, k[0] ? 8'h80 : 8'h00);
         cyc(3);
         chk({7'h0, irq}, 8'h01);
         acc(1'b1, radio_pkt_pkg::HREG_IRQ_STAT, 8'hff);
         cyc(4);
         chk({7'h0, irq}, 8'h00);
         cmd(8'h02);
      end
      // Raw stream with nobody reading, so the receive side must overflow
      acc(1'b1, radio_pkt_pkg::HREG_CTRL, 8'h00);
      cmd(8'h08);
      repeat (66) rx_byte(rnd());
      cyc(4);
      chk({4'h0, bus.radio_state}, {4'h0, radio_pkt_pkg::RS_RX_OVF});
      chk({7'h0, bus.gdo_out}, 8'h00);
      cmd(8'h02);
      cyc(2);
      cmd(8'h04);
      cyc(3);
      chk({1'b0, bus.rx_count}, 8'h00);
      acc(1'b1, radio_pkt_pkg::HREG_CTRL, 8'h03);
      acc(1'b1, radio_pkt_pkg::HREG_TXDATA, rnd());
      cmd(8'h01);
      cyc(100);
      cmd(8'h02);
      for (int i = 0; i < 1000 && bus.radio_state !== radio_pkt_pkg::RS_IDLE; i++) cyc(1);
      chk({7'h0, mod_fetch}, 8'h00);
      acc(1'b1, radio_pkt_pkg::HREG_CTRL, 8'h07);
      send_tx(8'h02);
      cmd(8'h01);
      repeat (2) begin
         cyc(3);
         for (int i = 0; i < 1000 && bus.tx_ready !== 1'b1; i++) cyc(1);
         send_tx(rnd());
      end
      for (int i = 0; i < 2000 && bus.radio_state !== radio_pkt_pkg::RS_IDLE; i++) cyc(1);
      chk({4'h0, bus.radio_state}, {4'h0, radio_pkt_pkg::RS_IDLE});
      chk(8'(tq.size()), 8'h00);
      summarize();
   end
   initial begin
      cyc(20000);
      err_count++;
      summarize();
   end
   task automatic summarize();
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
endmodule
